// ---- core/ofs_pkg.sv ----
// Constants and types for the operand fetch fork sequencer
package ofs_pkg;
  localparam int          WORD_W       = 16;
  localparam logic [15:0] PC_STEP      = 16'h0002;
  localparam logic [2:0]  MODE_REG     = 3'h0;
  localparam logic [2:0]  REG_PC       = 3'h7;
  localparam logic [2:0]  MODE_IMM     = 3'h2;
  localparam logic [2:0]  MODE_REL     = 3'h6;
  localparam logic [2:0]  MODE_RELDEF  = 3'h7;
  localparam logic [15:0] PC_RESET     = 16'h0000;

  // Instruction classes from the decoder
  typedef enum logic [1:0] {
    CLS_OTHER  = 2'h0,
    CLS_BINARY = 2'h1,
    CLS_SINGLE = 2'h2,
    CLS_FLOAT  = 2'h3
  } ofs_class_type;

  // Which operand a fetch sequence serves
  typedef enum logic [1:0] {
    OPD_NONE = 2'h0,
    OPD_SRC  = 2'h1,
    OPD_DST  = 2'h2
  } ofs_opd_type;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_AFORK  = 9'h002,
    ST_CALC   = 9'h004,
    ST_SETUP  = 9'h008,
    ST_XFER   = 9'h010,
    ST_NEXT   = 9'h020,
    ST_CFORK  = 9'h040,
    ST_BFORK  = 9'h080,
    ST_DONE   = 9'h100
  } ofs_state_type;

  // Purpose of the current bus cycle
  typedef enum logic [1:0] {
    CYC_OFFSET  = 2'h0,
    CYC_POINTER = 2'h1,
    CYC_OPERAND = 2'h2
  } ofs_cyc_type;
endpackage

// ---- core/ofs_addr_calc.sv ----
// Address formation for PC-relative operand modes (PC plus fetched offset)
`timescale 1ns/10ps
module ofs_addr_calc (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstSyncN,
  // Operands
  input  wire logic        loadEn,
  input  wire logic [15:0] baseVal,
  input  wire logic [15:0] offsetVal,
  // Result
  output logic      [15:0] sumOut
);
  logic [15:0] sum_r;
  logic [15:0] sum_nxt;

  always_comb begin
    sum_nxt = sum_r;
    if (loadEn) begin
      // Carry out of bit 15 is dropped on purpose
      sum_nxt = 16'(baseVal + offsetVal);
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sum_r <= ofs_pkg::PC_RESET;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  assign sumOut = sum_r;
endmodule

// ---- core/ofs_operand_fetch_fork_sequencer.sv ----
// Operand fetch fork sequencer: A, C and B fork dispatch with two-state transfers
`timescale 1ns/10ps
module ofs_operand_fetch_fork_sequencer (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Decoded instruction
  input  wire logic                  decodeValid,
  input  wire ofs_pkg::ofs_class_type instrClass,
  input  wire logic [2:0]            srcMode,
  input  wire logic [2:0]            srcReg,
  input  wire logic [2:0]            dstMode,
  input  wire logic [2:0]            dstReg,
  input  wire logic [15:0]           pcIn,
  input  wire logic [15:0]           srcRegVal,
  input  wire logic [15:0]           dstRegVal,
  // Memory side
  input  wire logic [15:0]           memRdata,
  output logic                       transferSetupCycle,
  output logic                       transferCycle,
  output logic [15:0]                memAddr,
  // Results
  output logic [15:0]                pcOut,
  output logic [15:0]                srcOperand,
  output logic [15:0]                dstOperand,
  output logic                       execStart,
  output logic                       busy,
  output logic                       sourceModeZeroClass,
  output logic                       destModeZeroClass
);
  // Reset release through two flops
  logic rstMeta_r;
  logic rstSyncN;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN  <= rstMeta_r;
    end
  end

  ofs_pkg::ofs_state_type state_r, state_nxt;
  ofs_pkg::ofs_opd_type   opd_r, opd_nxt;
  ofs_pkg::ofs_cyc_type   cyc_r, cyc_nxt;
  ofs_pkg::ofs_class_type cls_r, cls_nxt;
  logic [2:0]  sMode_r, sMode_nxt, dMode_r, dMode_nxt;
  logic [2:0]  sReg_r, sReg_nxt, dReg_r, dReg_nxt;
  logic [15:0] pc_r, pc_nxt, addr_r, addr_nxt;
  logic [15:0] src_r, src_nxt, dst_r, dst_nxt;
  logic [15:0] sVal_r, sVal_nxt, dVal_r, dVal_nxt;
  logic        setup_r, setup_nxt, xfer_r, xfer_nxt, exec_r, exec_nxt;
  logic        sm0_r, sm0_nxt, dm0_r, dm0_nxt;
  logic        busy_r, busy_nxt;
  logic        calcLoad;
  logic [15:0] calcOffset;
  logic [15:0] calcSum;
  logic [2:0]  curMode;
  logic [2:0]  curReg;
  logic [15:0] curVal;

  ofs_addr_calc uCalc (
    .mclk      (mclk),
    .rstSyncN  (rstSyncN),
    .loadEn    (calcLoad),
    .baseVal   (pc_r),
    .offsetVal (calcOffset),
    .sumOut    (calcSum)
  );

  always_comb begin
    curMode = (opd_r == ofs_pkg::OPD_SRC) ? sMode_r : dMode_r;
    curReg  = (opd_r == ofs_pkg::OPD_SRC) ? sReg_r : dReg_r;
    curVal  = (opd_r == ofs_pkg::OPD_SRC) ? sVal_r : dVal_r;
  end

  always_comb begin
    state_nxt = state_r;
    opd_nxt   = opd_r;
    cyc_nxt   = cyc_r;
    cls_nxt   = cls_r;
    sMode_nxt = sMode_r;
    dMode_nxt = dMode_r;
    sReg_nxt  = sReg_r;
    dReg_nxt  = dReg_r;
    sVal_nxt  = sVal_r;
    dVal_nxt  = dVal_r;
    pc_nxt    = pc_r;
    addr_nxt  = addr_r;
    src_nxt   = src_r;
    dst_nxt   = dst_r;
    setup_nxt = 1'b0;
    xfer_nxt  = 1'b0;
    exec_nxt  = 1'b0;
    sm0_nxt   = sm0_r;
    dm0_nxt   = dm0_r;
    calcLoad  = 1'b0;
    calcOffset = memRdata;
    case (state_r)
      ofs_pkg::ST_IDLE: begin
        if (decodeValid) begin
          cls_nxt   = instrClass;
          sMode_nxt = srcMode;
          dMode_nxt = dstMode;
          sReg_nxt  = srcReg;
          dReg_nxt  = dstReg;
          sVal_nxt  = srcRegVal;
          dVal_nxt  = dstRegVal;
          // Mode zero operands come straight from registers
          src_nxt   = srcRegVal;
          dst_nxt   = dstRegVal;
          pc_nxt    = pcIn;
          sm0_nxt   = (srcMode == ofs_pkg::MODE_REG);
          dm0_nxt   = (dstMode == ofs_pkg::MODE_REG);
          state_nxt = ofs_pkg::ST_AFORK;
        end
      end
      ofs_pkg::ST_AFORK: begin
        state_nxt = ofs_pkg::ST_BFORK;
        if (cls_r == ofs_pkg::CLS_BINARY && !sm0_r) begin
          opd_nxt   = ofs_pkg::OPD_SRC;
          state_nxt = ofs_pkg::ST_CALC;
        end else if ((cls_r == ofs_pkg::CLS_BINARY || cls_r == ofs_pkg::CLS_SINGLE) && !dm0_r) begin
          opd_nxt   = ofs_pkg::OPD_DST;
          state_nxt = ofs_pkg::ST_CALC;
        end
      end
      ofs_pkg::ST_CALC: begin
        // PC-based modes start at the PC; others use the register value
        if (curReg == ofs_pkg::REG_PC && (curMode == ofs_pkg::MODE_IMM ||
            curMode == ofs_pkg::MODE_REL || curMode == ofs_pkg::MODE_RELDEF)) begin
          addr_nxt = pc_r;
        end else begin
          addr_nxt = curVal;
        end
        cyc_nxt   = (curReg == ofs_pkg::REG_PC && curMode != ofs_pkg::MODE_IMM &&
                     (curMode == ofs_pkg::MODE_REL || curMode == ofs_pkg::MODE_RELDEF))
                    ? ofs_pkg::CYC_OFFSET : ofs_pkg::CYC_OPERAND;
        setup_nxt = 1'b1;
        state_nxt = ofs_pkg::ST_SETUP;
      end
      ofs_pkg::ST_SETUP: begin
        // Setup always precedes the moving cycle
        xfer_nxt  = 1'b1;
        state_nxt = ofs_pkg::ST_XFER;
      end
      ofs_pkg::ST_XFER: begin
        state_nxt = ofs_pkg::ST_NEXT;
        case (cyc_r)
          ofs_pkg::CYC_OFFSET: begin
            // Offset is added to the already stepped PC
            pc_nxt     = 16'(pc_r + ofs_pkg::PC_STEP);
            calcOffset = 16'(memRdata + ofs_pkg::PC_STEP);
            calcLoad   = 1'b1;
          end
          ofs_pkg::CYC_POINTER: begin
            addr_nxt = memRdata;
          end
          default: begin
            if (opd_r == ofs_pkg::OPD_SRC) begin
              src_nxt = memRdata;
            end else begin
              dst_nxt = memRdata;
            end
            if (curReg == ofs_pkg::REG_PC && curMode == ofs_pkg::MODE_IMM) begin
              pc_nxt = 16'(pc_r + ofs_pkg::PC_STEP);
            end
          end
        endcase
      end
      ofs_pkg::ST_NEXT: begin
        if (cyc_r == ofs_pkg::CYC_OFFSET) begin
          // Deferred goes via pointer: three cycles; plain relative two
          addr_nxt  = calcSum;
          cyc_nxt   = (curMode == ofs_pkg::MODE_RELDEF) ? ofs_pkg::CYC_POINTER
                      : ofs_pkg::CYC_OPERAND;
          setup_nxt = 1'b1;
          state_nxt = ofs_pkg::ST_SETUP;
        end else if (cyc_r == ofs_pkg::CYC_POINTER) begin
          // Pointer read done; third cycle fetches the operand
          cyc_nxt   = ofs_pkg::CYC_OPERAND;
          setup_nxt = 1'b1;
          state_nxt = ofs_pkg::ST_SETUP;
        end else begin
          state_nxt = (opd_r == ofs_pkg::OPD_SRC) ? ofs_pkg::ST_CFORK : ofs_pkg::ST_BFORK;
        end
      end
      ofs_pkg::ST_CFORK: begin
        state_nxt = ofs_pkg::ST_BFORK;
        if ((cls_r == ofs_pkg::CLS_FLOAT || cls_r == ofs_pkg::CLS_BINARY) && !dm0_r) begin
          opd_nxt   = ofs_pkg::OPD_DST;
          state_nxt = ofs_pkg::ST_CALC;
        end
      end
      ofs_pkg::ST_BFORK: begin
        exec_nxt  = 1'b1;
        opd_nxt   = ofs_pkg::OPD_NONE;
        state_nxt = ofs_pkg::ST_DONE;
      end
      ofs_pkg::ST_DONE: begin
        state_nxt = ofs_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = ofs_pkg::ST_IDLE;
      end
    endcase
    // Registered so busy comes straight from a flop
    busy_nxt = (state_nxt != ofs_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_r <= ofs_pkg::ST_IDLE;
      opd_r   <= ofs_pkg::OPD_NONE;
      cyc_r   <= ofs_pkg::CYC_OPERAND;
      cls_r   <= ofs_pkg::CLS_OTHER;
      sMode_r <= ofs_pkg::MODE_REG;
      dMode_r <= ofs_pkg::MODE_REG;
      sReg_r  <= ofs_pkg::MODE_REG;
      dReg_r  <= ofs_pkg::MODE_REG;
      sVal_r  <= ofs_pkg::PC_RESET;
      dVal_r  <= ofs_pkg::PC_RESET;
      pc_r    <= ofs_pkg::PC_RESET;
      addr_r  <= ofs_pkg::PC_RESET;
      src_r   <= ofs_pkg::PC_RESET;
      dst_r   <= ofs_pkg::PC_RESET;
      setup_r <= 1'b0;
      xfer_r  <= 1'b0;
      exec_r  <= 1'b0;
      sm0_r   <= 1'b1;
      dm0_r   <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opd_r   <= opd_nxt;
      cyc_r   <= cyc_nxt;
      cls_r   <= cls_nxt;
      sMode_r <= sMode_nxt;
      dMode_r <= dMode_nxt;
      sReg_r  <= sReg_nxt;
      dReg_r  <= dReg_nxt;
      sVal_r  <= sVal_nxt;
      dVal_r  <= dVal_nxt;
      pc_r    <= pc_nxt;
      addr_r  <= addr_nxt;
      src_r   <= src_nxt;
      dst_r   <= dst_nxt;
      setup_r <= setup_nxt;
      xfer_r  <= xfer_nxt;
      exec_r  <= exec_nxt;
      sm0_r   <= sm0_nxt;
      dm0_r   <= dm0_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign transferSetupCycle  = setup_r;
  assign transferCycle       = xfer_r;
  assign memAddr             = addr_r;
  assign pcOut               = pc_r;
  assign srcOperand          = src_r;
  assign dstOperand          = dst_r;
  assign execStart           = exec_r;
  assign busy                = busy_r;
  assign sourceModeZeroClass = sm0_r;
  assign destModeZeroClass   = dm0_r;
endmodule

// ---- tb/ofs_checker.sv ----
// Assertion checker for the operand fetch fork sequencer
`timescale 1ns/10ps
module ofs_checker (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   resetn,
  // Decode side
  input wire logic                   decodeValid,
  input wire ofs_pkg::ofs_class_type instrClass,
  input wire logic [2:0]             srcMode,
  input wire logic [2:0]             dstMode,
  input wire logic [2:0]             dstReg,
  input wire logic [15:0]            pcIn,
  // Outputs watched
  input wire logic                   busy,
  input wire logic                   transferSetupCycle,
  input wire logic                   transferCycle,
  input wire logic [15:0]            memAddr,
  input wire logic [15:0]            pcOut,
  input wire logic                   execStart,
  input wire logic                   sourceModeZeroClass
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Float class left out: its fork path is not pinned down
  wire logic direct = decodeValid && !busy && instrClass != ofs_pkg::CLS_FLOAT &&
                      (instrClass == ofs_pkg::CLS_OTHER || (srcMode == 3'h0 && dstMode == 3'h0));
  wire logic immDst = execStart && instrClass == ofs_pkg::CLS_SINGLE &&
                      dstMode == ofs_pkg::MODE_IMM && dstReg == ofs_pkg::REG_PC;
  sequence s_xfer;
    transferSetupCycle ##1 transferCycle;
  endsequence
  sequence s_quiet3;
    !transferSetupCycle [*3];
  endsequence
  property p_setup_then_xfer;
    transferSetupCycle |-> s_xfer;
  endproperty
  property p_xfer_after_setup;
    transferCycle |-> $past(transferSetupCycle);
  endproperty
  property p_addr_stable;
    transferSetupCycle |=> $stable(memAddr);
  endproperty
  property p_setup_busy;
    transferSetupCycle |-> busy;
  endproperty
  property p_direct_exec;
    direct |-> s_quiet3 ##1 execStart;
  endproperty
  property p_exec_pulse;
    execStart |=> !execStart;
  endproperty
  property p_zero_flag;
    execStart |-> sourceModeZeroClass == (srcMode == 3'h0);
  endproperty
  property p_imm_pc;
    immDst |-> pcOut == pcIn + ofs_pkg::PC_STEP;
  endproperty
  a_setup_then_xfer: assert property (p_setup_then_xfer) else $error("setup not followed by transfer");
  a_xfer_after_setup: assert property (p_xfer_after_setup) else $error("transfer without setup");
  a_addr_stable: assert property (p_addr_stable) else $error("address moved during transfer");
  a_setup_busy: assert property (p_setup_busy) else $error("transfer while idle");
  a_direct_exec: assert property (p_direct_exec) else $error("direct instruction late or used bus");
  a_exec_pulse: assert property (p_exec_pulse) else $error("execute pulse too long");
  a_zero_flag: assert property (p_zero_flag) else $error("source zero flag wrong");
  a_imm_pc: assert property (p_imm_pc) else $error("immediate step of PC wrong");
endmodule

bind ofs_operand_fetch_fork_sequencer ofs_checker CHKR (
  .mclk(mclk), .resetn(resetn), .decodeValid(decodeValid), .instrClass(instrClass),
  .srcMode(srcMode), .dstMode(dstMode), .dstReg(dstReg), .pcIn(pcIn), .busy(busy),
  .transferSetupCycle(transferSetupCycle), .transferCycle(transferCycle), .memAddr(memAddr),
  .pcOut(pcOut), .execStart(execStart), .sourceModeZeroClass(sourceModeZeroClass)
);

// ---- tb/ofs_mem_model.sv ----
// Behavioural memory answering the sequencer's transfers
`timescale 1ns/10ps
module ofs_mem_model (
  // Clock
  input  wire logic        mclk,
  // Transfer side
  input  wire logic        transferCycle,
  input  wire logic [15:0] memAddr,
  output logic      [15:0] memRdata
);
  logic [15:0] mem [0:255];
  logic [15:0] lastData;
  initial lastData = 16'h0000;
  // Valid only in the transfer state, junk otherwise so late sampling shows
  always_comb begin
    if (transferCycle) begin
      memRdata = mem[memAddr[8:1]];
    end else begin
      memRdata = ~lastData;
    end
  end
  always @(posedge mclk) begin
    if (transferCycle) begin
      lastData <= memRdata;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the operand fetch fork sequencer
`timescale 1ns/10ps
`define CHECK(act, exp) begin cmpCount++; if ((act) !== (exp)) begin numErrors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp); end end
module tb;
  logic                   mclk, resetn, decodeValid, tSetup, tXfer, execStart, busy, szFlag, dzFlag;
  ofs_pkg::ofs_class_type instrClass;
  logic [2:0]             srcMode, srcReg, dstMode, dstReg;
  logic [15:0]            pcIn, srcRegVal, dstRegVal, memRdata, memAddr, pcOut, srcOp, dstOp;
  int                     numErrors, cmpCount, busCount;

  ofs_operand_fetch_fork_sequencer DUT (
    .mclk(mclk), .resetn(resetn), .decodeValid(decodeValid), .instrClass(instrClass),
    .srcMode(srcMode), .srcReg(srcReg), .dstMode(dstMode), .dstReg(dstReg), .pcIn(pcIn),
    .srcRegVal(srcRegVal), .dstRegVal(dstRegVal), .memRdata(memRdata),
    .transferSetupCycle(tSetup), .transferCycle(tXfer), .memAddr(memAddr), .pcOut(pcOut),
    .srcOperand(srcOp), .dstOperand(dstOp), .execStart(execStart), .busy(busy),
    .sourceModeZeroClass(szFlag), .destModeZeroClass(dzFlag)
  );
  ofs_mem_model MEM (.mclk(mclk), .transferCycle(tXfer), .memAddr(memAddr), .memRdata(memRdata));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (tSetup === 1'b1) begin
      busCount++;
    end
  end

  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      numErrors++;
      $display("wait limit reached t=%0t", $time);
      closeOut();
    end
  endtask
  // Fields held until idle, so the checker can relate them to results
  task automatic runOp(input ofs_pkg::ofs_class_type cls, input logic [2:0] sm, sr, dm, dr,
                       input logic [15:0] pc);
    int n;
    instrClass = cls;
    srcMode = sm;
    srcReg = sr;
    dstMode = dm;
    dstReg = dr;
    pcIn = pc;
    busCount = 0;
    decodeValid = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    decodeValid = 1'b0;
    guard(n, 20);
    n = 0;
    while (execStart !== 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 80);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 20);
  endtask

  task automatic testDirect();
    runOp(ofs_pkg::CLS_BINARY, 3'h0, 3'h1, 3'h0, 3'h2, 16'h0100);
    `CHECK(busCount, 0)
    `CHECK(srcOp, srcRegVal)
    `CHECK(dstOp, dstRegVal)
    `CHECK(dzFlag, 1'b1)
    runOp(ofs_pkg::CLS_OTHER, 3'h6, 3'h7, 3'h6, 3'h7, 16'h0100);
    `CHECK(busCount, 0)
    runOp(ofs_pkg::CLS_SINGLE, 3'h0, 3'h0, 3'h0, 3'h3, 16'h0100);
    `CHECK(busCount, 0)
    $display("direct test done");
  endtask
  task automatic testImm();
    MEM.mem[8'h80] = 16'h1357;
    runOp(ofs_pkg::CLS_SINGLE, 3'h0, 3'h0, ofs_pkg::MODE_IMM, ofs_pkg::REG_PC, 16'h0100);
    `CHECK(dstOp, 16'h1357)
    `CHECK(pcOut, 16'h0102)
    `CHECK(busCount, 1)
    MEM.mem[8'h1E] = 16'h5A5A;
    runOp(ofs_pkg::CLS_SINGLE, 3'h0, 3'h0, 3'h1, 3'h3, 16'h0100);
    `CHECK(dstOp, 16'h5A5A)
    `CHECK(pcOut, 16'h0100)
    `CHECK(busCount, 1)
    $display("immediate test done");
  endtask
  task automatic testRel();
    MEM.mem[8'h10] = 16'h0054;
    MEM.mem[8'h3B] = 16'h2468;
    runOp(ofs_pkg::CLS_SINGLE, 3'h0, 3'h0, ofs_pkg::MODE_REL, ofs_pkg::REG_PC, 16'h0020);
    `CHECK(dstOp, 16'h2468)
    `CHECK(pcOut, 16'h0022)
    `CHECK(busCount, 2)
    $display("relative test done");
  endtask
  // Deferred source then relative destination on the second fork
  task automatic testRelDef();
    MEM.mem[8'h20] = 16'h0010;
    MEM.mem[8'h29] = 16'h0090;
    MEM.mem[8'h48] = 16'hBEEF;
    MEM.mem[8'h21] = 16'h0006;
    MEM.mem[8'h25] = 16'h1234;
    runOp(ofs_pkg::CLS_BINARY, ofs_pkg::MODE_RELDEF, ofs_pkg::REG_PC, ofs_pkg::MODE_REL,
          ofs_pkg::REG_PC, 16'h0040);
    `CHECK(srcOp, 16'hBEEF)
    `CHECK(dstOp, 16'h1234)
    `CHECK(busCount, 5)
    `CHECK(pcOut, 16'h0044)
    `CHECK(szFlag, 1'b0)
    $display("deferred test done");
  endtask
  task automatic testWrap();
    MEM.mem[8'hFE] = 16'h0010;
    MEM.mem[8'h07] = 16'h0F0F;
    runOp(ofs_pkg::CLS_SINGLE, 3'h0, 3'h0, ofs_pkg::MODE_REL, ofs_pkg::REG_PC, 16'hFFFC);
    `CHECK(dstOp, 16'h0F0F)
    `CHECK(pcOut, 16'hFFFE)
    $display("wrap test done");
  endtask

  initial begin
    numErrors = 0;
    cmpCount = 0;
    busCount = 0;
    resetn = 1'b0;
    decodeValid = 1'b0;
    instrClass = ofs_pkg::CLS_OTHER;
    srcMode = 3'h0;
    srcReg = 3'h0;
    dstMode = 3'h0;
    dstReg = 3'h0;
    pcIn = 16'h0000;
    srcRegVal = 16'hA5A5;
    dstRegVal = 16'h3C3C;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    testDirect();
    testImm();
    testRel();
    testRelDef();
    testWrap();
    closeOut();
  end
endmodule
